// file: acsc_pkg.sv
// Constants for the converter sequence and compare control block.
// Assumes one converter clock domain and a 32-bit AHB-Lite register bus.
package acsc_pkg;

    // ------------------------------------------------------------
    // Widths and sizes
    // ------------------------------------------------------------
    localparam int ACSC_IDX_W = 8;
    localparam int ACSC_NUM_CMP = 12;
    localparam int ACSC_NUM_SLOT = 16;
    localparam int ACSC_RES_W = 10;
    localparam int ACSC_CNT_W = 4;

    // ------------------------------------------------------------
    // Register indices, byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [7:0] ACSC_IDX_CTL5 = 8'h05;
    localparam logic [7:0] ACSC_IDX_COMPARE_ENABLE_BITS = 8'h08;
    localparam logic [7:0] ACSC_IDX_DIEN = 8'h0C;
    localparam logic [7:0] ACSC_IDX_COMPARE_ABOVE_SELECT = 8'h0E;
    localparam logic [7:0] ACSC_IDX_CFG = 8'h10;
    localparam logic [7:0] ACSC_IDX_STAT0 = 8'h11;
    localparam logic [7:0] ACSC_IDX_STAT2 = 8'h12;
    localparam logic [7:0] ACSC_IDX_MASK = 8'h13;
    localparam logic [3:0] ACSC_IDX_SLOT_HI = 4'h2;

    // ------------------------------------------------------------
    // Field layouts and reset values
    // ------------------------------------------------------------
    localparam int ACSC_CTL5_SC = 6;
    localparam int ACSC_CTL5_SCAN = 5;
    localparam logic [7:0] ACSC_CTL5_WMASK = 8'h6F;
    localparam int ACSC_CFG_ETRIG = 0;
    localparam int ACSC_CFG_FIFO = 1;
    localparam int ACSC_CFG_SMP_LSB = 2;
    localparam int ACSC_CFG_LEN_LSB = 8;
    localparam logic [11:0] ACSC_CFG_WMASK = 12'hF1F;
    localparam int ACSC_STAT2_SEQ = 15;
    localparam logic [15:0] ACSC_STAT_RST = 16'h0000;

    // ------------------------------------------------------------
    // Sample time coding in converter clock cycles
    // ------------------------------------------------------------
    localparam logic [2:0] ACSC_SMP_CODE_MAX = 3'h7;
    localparam logic [4:0] ACSC_SMP_MAX_CYC = 5'h18;

    function automatic logic [4:0] acsc_smp_cycles(input logic [2:0] code);
        logic [4:0] cyc;
        case (code)
            3'h0: cyc = 5'h04;
            3'h1: cyc = 5'h06;
            3'h2: cyc = 5'h08;
            3'h3: cyc = 5'h0A;
            3'h4: cyc = 5'h0C;
            3'h5: cyc = 5'h10;
            3'h6: cyc = 5'h14;
            default: cyc = ACSC_SMP_MAX_CYC;
        endcase
        return cyc;
    endfunction

    typedef enum logic [1:0] {
        ACSC_ST_IDLE = 2'b00,
        ACSC_ST_SAMPLE = 2'b01,
        ACSC_ST_CONVERT = 2'b10
    } acsc_state_t;

endpackage

// file: acsc_ctrl.sv
// Sequence, sample-time and compare control for a multiplexed SAR converter.
// Assumes the analog core shares clk and pulses conv_done with conv_result.
// Operation
// - Writing the start register aborts any sequence and starts a new one.
// - With external trigger on, one start write arms; each trigger then starts.
// - A conversion starts with the first cycle of its sampling phase.
// - Sample time code all ones gives 24 converter clock cycles.
// - Start bit 6 enables special-channel conversion using the channel code.
// - Start bit 5 picks one sequence (0) or continuous sequences (1).
// - External trigger on: continuous bit ignored, one sequence per trigger.
// - A 4-bit read-only counter names the slot receiving the current result.
// - Without FIFO mode the counter clears at sequence start and end.
// - The counter wraps to zero after its maximum and keeps counting.
// - Writing compare enable or direction aborts the running sequence.
// - Twelve compare enables select positions by conversion number.
// - Each position reports a successful compare in its own status flag.
// - Direction 0 flags result at or below value; 1 flags result above.
// - Twelve input enable bits hold digital input buffers on while set.
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module acsc_ctrl
    import acsc_pkg::*;
#(
    parameter int NUM_CMP = ACSC_NUM_CMP,
    parameter int RES_W = ACSC_RES_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic ext_trigger_pin,
    output logic conv_start,
    output logic sample_active,
    output logic [3:0] conv_channel,
    output logic conv_special,
    input wire logic conv_done,
    input wire logic [RES_W-1:0] conv_result,
    output logic [NUM_CMP-1:0] digital_input_buffer_enable,
    output logic irq
);

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic ap_valid_r;
    logic ap_write_r;
    logic [ACSC_IDX_W-1:0] ap_idx_r;
    logic [31:0] hrdata_r;
    logic [31:0] rd_val;

    // Address phase taken only when enabled; a frozen block holds the bus.
    wire logic ap_take = hsel && htrans[1] && hready && ce;
    wire logic [ACSC_IDX_W-1:0] ap_idx = haddr[ACSC_IDX_W+1:2];
    wire logic dp_wr = ap_valid_r && ap_write_r && ce;
    wire logic wr_ctl5 = dp_wr && (ap_idx_r == ACSC_IDX_CTL5);
    wire logic wr_cmp = dp_wr && ((ap_idx_r == ACSC_IDX_COMPARE_ENABLE_BITS) || (ap_idx_r == ACSC_IDX_COMPARE_ABOVE_SELECT));
    wire logic wr_slot = dp_wr && (ap_idx_r[7:4] == ACSC_IDX_SLOT_HI);
    wire logic rd_stat2 = ap_take && !hwrite && (ap_idx == ACSC_IDX_STAT2);

    assign hrdata = hrdata_r;
    assign hreadyout = ce;
    assign hresp = 1'h0;

    // Address phase capture; read data is latched so the data phase has zero waits.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ap_valid_r <= 1'h0;
            ap_write_r <= 1'h0;
            ap_idx_r <= '0;
            hrdata_r <= 32'h0000_0000;
        end else if (ce) begin
            ap_valid_r <= ap_take;
            ap_write_r <= hwrite;
            ap_idx_r <= ap_idx;
            if (ap_take && !hwrite) begin
                hrdata_r <= rd_val;
            end
        end
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    logic [7:0] ctl5_r;
    logic [NUM_CMP-1:0] compare_enable_bits_r;
    logic [NUM_CMP-1:0] dien_r;
    logic [NUM_CMP-1:0] compare_above_select_r;
    logic [11:0] cfg_r;
    logic [15:0] mask_r;

    // Plain stores; side effects of these writes live in the sequencer.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctl5_r <= 8'h00;
            compare_enable_bits_r <= '0;
            dien_r <= '0;
            compare_above_select_r <= '0;
            cfg_r <= 12'h000;
            mask_r <= ACSC_STAT_RST;
        end else if (dp_wr) begin
            case (ap_idx_r)
                ACSC_IDX_CTL5: ctl5_r <= hwdata[7:0] & ACSC_CTL5_WMASK;
                ACSC_IDX_COMPARE_ENABLE_BITS: compare_enable_bits_r <= hwdata[NUM_CMP-1:0];
                ACSC_IDX_DIEN: dien_r <= hwdata[NUM_CMP-1:0];
                ACSC_IDX_COMPARE_ABOVE_SELECT: compare_above_select_r <= hwdata[NUM_CMP-1:0];
                ACSC_IDX_CFG: cfg_r <= hwdata[11:0] & ACSC_CFG_WMASK;
                ACSC_IDX_MASK: mask_r <= hwdata[15:0];
                default: ;
            endcase
        end
    end

    // Buffers stay on for as long as the bit is set, whatever the sequencer does.
    assign digital_input_buffer_enable = dien_r;

    wire logic ext_en = cfg_r[ACSC_CFG_ETRIG];
    wire logic fifo_en = cfg_r[ACSC_CFG_FIFO];
    wire logic [2:0] smp_code = cfg_r[ACSC_CFG_SMP_LSB +: 3];
    wire logic [3:0] len_m1 = cfg_r[ACSC_CFG_LEN_LSB +: 4];
    wire logic sc_en = ctl5_r[ACSC_CTL5_SC];
    // A start write launches with the value being written, not the register's old one.
    wire logic [7:0] ctl5_eff = wr_ctl5 ? (hwdata[7:0] & ACSC_CTL5_WMASK) : ctl5_r;
    wire logic sc_eff = ctl5_eff[ACSC_CTL5_SC];
    wire logic [3:0] ch_code = ctl5_eff[3:0];
    // The trigger owns sequencing, so the scan bit is masked off under it.
    wire logic scan_eff = ctl5_r[ACSC_CTL5_SCAN] && !ext_en;

    // ------------------------------------------------------------
    // External trigger synchroniser
    // ------------------------------------------------------------
    logic [2:0] trig_sync_r;
    logic trig_lvl_r;

    // A change counts only once the second and third stages agree.
    wire logic trig_rise = (trig_sync_r[1] == trig_sync_r[2]) && trig_sync_r[1] && !trig_lvl_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trig_sync_r <= 3'h0;
            trig_lvl_r <= 1'h0;
        end else if (ce) begin
            trig_sync_r <= {trig_sync_r[1:0], ext_trigger_pin};
            if (trig_sync_r[1] == trig_sync_r[2]) begin
                trig_lvl_r <= trig_sync_r[1];
            end
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    acsc_state_t state_r, state_nxt;
    logic [4:0] samp_cnt_r, samp_cnt_nxt;
    logic [3:0] idx_r, idx_nxt;
    logic [ACSC_CNT_W-1:0] cnt_r, cnt_nxt;
    logic [3:0] chan_r, chan_nxt;
    logic start_r, start_nxt;
    logic armed_r;

    wire logic done_evt = (state_r == ACSC_ST_CONVERT) && conv_done;
    wire logic last = (idx_r == len_m1);
    wire logic seq_end = done_evt && last;
    wire logic [ACSC_CNT_W-1:0] cnt_inc = cnt_r + 4'h1;
    // Start write launches at once; under the trigger it aborts and arms.
    wire logic launch = (wr_ctl5 && !ext_en)
        || (trig_rise && ext_en && armed_r)
        || (seq_end && scan_eff && !wr_cmp);
    wire logic abort = wr_cmp || (wr_ctl5 && ext_en);

    // Next-state logic; a launch beats an abort arriving in the same cycle.
    always_comb begin
        state_nxt = state_r;
        samp_cnt_nxt = samp_cnt_r;
        idx_nxt = idx_r;
        cnt_nxt = cnt_r;
        start_nxt = 1'h0;
        if (launch) begin
            state_nxt = ACSC_ST_SAMPLE;
            samp_cnt_nxt = acsc_smp_cycles(smp_code) - 5'h01;
            idx_nxt = 4'h0;
            cnt_nxt = fifo_en ? (done_evt ? cnt_inc : cnt_r) : 4'h0;
            start_nxt = 1'h1;
        end else if (abort) begin
            state_nxt = ACSC_ST_IDLE;
            cnt_nxt = fifo_en ? cnt_r : 4'h0;
        end else begin
            case (state_r)
                ACSC_ST_IDLE: ;
                ACSC_ST_SAMPLE: begin
                    if (samp_cnt_r == 5'h00) begin
                        state_nxt = ACSC_ST_CONVERT;
                    end else begin
                        samp_cnt_nxt = samp_cnt_r - 5'h01;
                    end
                end
                ACSC_ST_CONVERT: begin
                    if (conv_done) begin
                        cnt_nxt = cnt_inc;
                        if (last) begin
                            state_nxt = ACSC_ST_IDLE;
                            if (!fifo_en) begin
                                cnt_nxt = 4'h0;
                            end
                        end else begin
                            state_nxt = ACSC_ST_SAMPLE;
                            idx_nxt = idx_r + 4'h1;
                            samp_cnt_nxt = acsc_smp_cycles(smp_code) - 5'h01;
                            start_nxt = 1'h1;
                        end
                    end
                end
                default: state_nxt = ACSC_ST_IDLE;
            endcase
        end
        chan_nxt = start_nxt ? (sc_eff ? ch_code : ch_code + idx_nxt) : chan_r;
    end

    // Sequencer registers, all frozen while the clock enable is low.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= ACSC_ST_IDLE;
            samp_cnt_r <= 5'h00;
            idx_r <= 4'h0;
            cnt_r <= 4'h0;
            chan_r <= 4'h0;
            start_r <= 1'h0;
            armed_r <= 1'h0;
        end else if (ce) begin
            state_r <= state_nxt;
            samp_cnt_r <= samp_cnt_nxt;
            idx_r <= idx_nxt;
            cnt_r <= cnt_nxt;
            chan_r <= chan_nxt;
            start_r <= start_nxt;
            armed_r <= ext_en && (armed_r || wr_ctl5);
        end
    end

    assign conv_start = start_r;
    assign sample_active = (state_r == ACSC_ST_SAMPLE);
    assign conv_channel = chan_r;
    assign conv_special = sc_en;

    // ------------------------------------------------------------
    // Result slots and compare
    // ------------------------------------------------------------
    logic [RES_W-1:0] slot_r [ACSC_NUM_SLOT];
    logic [15:0] flag_set;
    logic [15:0] stat2_r;

    wire logic [RES_W-1:0] cur_slot = slot_r[cnt_r];
    wire logic cmp_on_cur = (32'(idx_r) < NUM_CMP) && compare_enable_bits_r[idx_r];
    wire logic compare_above_select_cur = compare_above_select_r[idx_r];
    // A compare-enabled result is not stored, so the reference survives the next pass.
    wire logic res_wr = done_evt && !cmp_on_cur;

    // One storage entry per slot; a converter result beats a bus write.
    for (genvar s = 0; s < ACSC_NUM_SLOT; s++) begin : g_slot
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                slot_r[s] <= '0;
            end else if (ce) begin
                if (res_wr && (cnt_r == s)) begin
                    slot_r[s] <= conv_result;
                end else if (wr_slot && (ap_idx_r[3:0] == s)) begin
                    slot_r[s] <= hwdata[RES_W-1:0];
                end
            end
        end
    end

    // Per-position compare evaluated at the end of that conversion.
    for (genvar p = 0; p < 16; p++) begin : g_cmp
        if (p < NUM_CMP) begin : g_on
            assign flag_set[p] = done_evt && compare_enable_bits_r[p] && (idx_r == p)
                && (compare_above_select_r[p] ? (conv_result > cur_slot)
                : (conv_result <= cur_slot));
        end else if (p == ACSC_STAT2_SEQ) begin : g_seq
            assign flag_set[p] = seq_end;
        end else begin : g_off
            assign flag_set[p] = 1'h0;
        end
    end

    // Sticky flags cleared by a status read; an event in the same cycle wins.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stat2_r <= ACSC_STAT_RST;
        end else if (ce) begin
            stat2_r <= (stat2_r & ~{16{rd_stat2}}) | flag_set;
        end
    end

    assign irq = |(stat2_r & mask_r);

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    wire logic busy = (state_r != ACSC_ST_IDLE);

    always_comb begin
        rd_val = 32'h0000_0000;
        case (ap_idx)
            ACSC_IDX_CTL5: rd_val = 32'(ctl5_r);
            ACSC_IDX_COMPARE_ENABLE_BITS: rd_val = 32'(compare_enable_bits_r);
            ACSC_IDX_DIEN: rd_val = 32'(dien_r);
            ACSC_IDX_COMPARE_ABOVE_SELECT: rd_val = 32'(compare_above_select_r);
            ACSC_IDX_CFG: rd_val = 32'(cfg_r);
            ACSC_IDX_STAT0: rd_val = 32'({armed_r, busy, 4'h0, cnt_r});
            ACSC_IDX_STAT2: rd_val = 32'(stat2_r);
            ACSC_IDX_MASK: rd_val = 32'(mask_r);
            default: begin
                if (ap_idx[7:4] == ACSC_IDX_SLOT_HI) begin
                    rd_val = 32'(slot_r[ap_idx[3:0]]);
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic [4:0] chk_run_r;
    logic [4:0] chk_len_r;

    // Counts the cycles actually spent sampling against the length chosen at start.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chk_run_r <= 5'h00;
            chk_len_r <= 5'h00;
        end else if (ce) begin
            chk_run_r <= start_nxt ? 5'h01 : (sample_active ? chk_run_r + 5'h01 : 5'h00);
            if (start_nxt) begin
                chk_len_r <= (smp_code == ACSC_SMP_CODE_MAX) ? ACSC_SMP_MAX_CYC
                    : acsc_smp_cycles(smp_code);
            end
        end
    end

    sequence s_cmp_done;
        done_evt && cmp_on_cur;
    endsequence

    property p_wr_start;
        @(posedge clk) disable iff (rst || !ce)
        (wr_ctl5 && !ext_en) |=> (state_r == ACSC_ST_SAMPLE) && conv_start && (idx_r == 4'h0);
    endproperty
    a_wr_start: assert property (p_wr_start) else $error("Start write did not restart.");

    property p_trig;
        @(posedge clk) disable iff (rst || !ce)
        (ext_en && !armed_r && !wr_ctl5 && !busy) |=> !conv_start;
    endproperty
    a_trig: assert property (p_trig) else $error("Trigger started while unarmed.");

    property p_start_phase;
        @(posedge clk) disable iff (rst)
        conv_start |-> sample_active && (chk_run_r == 5'h01);
    endproperty
    a_start_phase: assert property (p_start_phase) else $error("Start not in sampling.");

    property p_smp_len;
        @(posedge clk) disable iff (rst || !ce)
        (sample_active && (state_nxt == ACSC_ST_CONVERT)) |-> (chk_run_r == chk_len_r);
    endproperty
    a_smp_len: assert property (p_smp_len) else $error("Sampling length wrong.");

    property p_scan;
        @(posedge clk) disable iff (rst || !ce)
        (seq_end && scan_eff && !abort) |=> conv_start && (idx_r == 4'h0);
    endproperty
    a_scan: assert property (p_scan) else $error("Continuous mode did not restart.");

    property p_trig_single;
        @(posedge clk) disable iff (rst || !ce)
        (seq_end && ext_en && !launch) |=> (state_r == ACSC_ST_IDLE);
    endproperty
    a_trig_single: assert property (p_trig_single) else $error("Trigger ran on.");

    property p_cnt_clr;
        @(posedge clk) disable iff (rst || !ce)
        ((launch || seq_end) && !fifo_en) |=> (cnt_r == 4'h0);
    endproperty
    a_cnt_clr: assert property (p_cnt_clr) else $error("Counter not cleared.");

    property p_cnt_wrap;
        @(posedge clk) disable iff (rst || !ce)
        (done_evt && fifo_en && !abort) |=> (cnt_r == 4'($past(cnt_r) + 4'h1));
    endproperty
    a_cnt_wrap: assert property (p_cnt_wrap) else $error("Counter did not advance.");

    property p_cmp_abort;
        @(posedge clk) disable iff (rst || !ce)
        (wr_cmp && !launch) |=> (state_r == ACSC_ST_IDLE) && !conv_start;
    endproperty
    a_cmp_abort: assert property (p_cmp_abort) else $error("Compare write no abort.");

    property p_cmp_hi;
        @(posedge clk) disable iff (rst || !ce)
        (s_cmp_done and (compare_above_select_cur && (conv_result > cur_slot))) |=> stat2_r[$past(idx_r)];
    endproperty
    a_cmp_hi: assert property (p_cmp_hi) else $error("Higher compare not flagged.");

    property p_cmp_lo;
        @(posedge clk) disable iff (rst || !ce)
        (s_cmp_done and (!compare_above_select_cur && (conv_result <= cur_slot))) |=> stat2_r[$past(idx_r)];
    endproperty
    a_cmp_lo: assert property (p_cmp_lo) else $error("Lower compare not flagged.");

endmodule // acsc_ctrl
`default_nettype wire

// file: acsc_core_model.sv
// Behavioural model of the analog sample and successive approximation core.
// Assumes it shares clk with the controller and follows its sampling strobe.
`timescale 1ns/1ns
`default_nettype none
module acsc_core_model
    import acsc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic conv_start,
    input wire logic sample_active,
    input wire logic [3:0] delay,
    input wire logic [ACSC_RES_W-1:0] value,
    output logic conv_done,
    output logic [ACSC_RES_W-1:0] conv_result
);
    logic prev_r;
    logic busy_r;
    logic [3:0] cnt_r;

    // Convert once sampling ends and answer after delay cycles; a new start drops
    // the old conversion. The result bus toggles outside the done pulse so that a
    // stale value is never mistaken for a valid one.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_r <= 1'b0;
            busy_r <= 1'b0;
            cnt_r <= 4'h0;
            conv_done <= 1'b0;
            conv_result <= '0;
        end else begin
            prev_r <= sample_active;
            conv_done <= 1'b0;
            conv_result <= ~conv_result;
            if (conv_start) begin
                busy_r <= 1'b0;
            end else if (prev_r && !sample_active) begin
                busy_r <= 1'b1;
                cnt_r <= delay;
            end else if (busy_r && cnt_r == 4'h0) begin
                busy_r <= 1'b0;
                conv_done <= 1'b1;
                conv_result <= value;
            end else if (busy_r) begin
                cnt_r <= cnt_r - 4'h1;
            end
        end
    end
endmodule // acsc_core_model
`default_nettype wire

// file: acsc_ctrl_bench.sv
// Self-checking bench for the converter sequence and compare controller.
// Assumes one 250 MHz clock and a zero-wait AHB-Lite slave.
`timescale 1ns/1ns
`default_nettype none
module acsc_ctrl_bench
    import acsc_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic trig = 1'b0;
    logic [3:0] delay = 4'h1;
    logic [9:0] value = '0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, conv_start, sample_active, conv_special, conv_done, irq;
    logic [3:0] conv_channel;
    logic [9:0] conv_result;
    logic [11:0] dibe;
    logic [31:0] d;
    int n_errors = 0;
    int n_tests = 0;
    int n_starts = 0;

    always #2 clk = ~clk;

    // Count conversion starts so scenarios can tell how many conversions began.
    always @(posedge clk) if (conv_start === 1'b1) n_starts <= n_starts + 1;

    acsc_ctrl acsc_ctrl_inst (.clk(clk), .rst(rst), .ce(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_trigger_pin(trig),
        .conv_start(conv_start), .sample_active(sample_active), .conv_channel(conv_channel),
        .conv_special(conv_special), .conv_done(conv_done), .conv_result(conv_result),
        .digital_input_buffer_enable(dibe), .irq(irq));

    acsc_core_model acsc_core_model_inst (.clk(clk), .rst(rst), .conv_start(conv_start),
        .sample_active(sample_active), .delay(delay), .value(value),
        .conv_done(conv_done), .conv_result(conv_result));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One single word transfer; ends half a cycle later so register outputs settle.
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd,
            output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk("hresp", 0, hresp);
        @(negedge clk);
    endtask

    task automatic wait_start();
        int k;
        for (k = 0; k < 60 && conv_start !== 1'b1; k++) @(negedge clk);
        chk("start seen", 1, conv_start);
    endtask

    task automatic wait_done();
        int k;
        d = 32'h0000_0100;
        for (k = 0; k < 80 && d[8] !== 1'b0; k++) bus(0, ACSC_IDX_STAT0, '0, d);
        chk("sequence done", 0, d[8]);
    endtask

    task automatic sc_regs();
        bus(1, ACSC_IDX_DIEN, 12'hABC, d);
        chk("input enable", 12'hABC, dibe);
        bus(0, ACSC_IDX_DIEN, '0, d);
        chk("input enable readback", 12'hABC, d);
        bus(0, 8'h3F, '0, d);
        chk("unmapped read", 0, d);
    endtask

    task automatic sc_sample();
        int k;
        bus(1, ACSC_IDX_CFG, 12'h01C, d);
        bus(1, ACSC_IDX_CTL5, 8'h43, d);
        wait_start();
        chk("sampling at start", 1, sample_active);
        chk("special enable", 1, conv_special);
        chk("channel code", 3, conv_channel);
        for (k = 0; k < 40 && sample_active === 1'b1; k++) @(negedge clk);
        chk("sample cycles", 24, k);
        wait_done();
        chk("counter at end", 0, d[3:0]);
    endtask

    task automatic sc_compare();
        logic [15:0] exp [2] = '{16'h8001, 16'h8002};
        int i;
        bus(1, {4'h2, 4'h0}, 10'h064, d);
        bus(1, {4'h2, 4'h1}, 10'h064, d);
        bus(1, ACSC_IDX_COMPARE_ABOVE_SELECT, 12'h002, d);
        bus(1, ACSC_IDX_COMPARE_ENABLE_BITS, 12'h003, d);
        bus(1, ACSC_IDX_MASK, 16'h0001, d);
        bus(1, ACSC_IDX_CFG, 12'h100, d);
        for (i = 0; i < 2; i++) begin
            @(posedge clk);
            value <= 10'h064 + 10'(i);
            bus(0, ACSC_IDX_STAT2, '0, d);
            bus(1, ACSC_IDX_CTL5, 8'h05, d);
            wait_done();
            chk("irq", exp[i][0], irq);
            bus(0, ACSC_IDX_STAT2, '0, d);
            chk("compare flags", exp[i], d);
            chk("irq cleared", 0, irq);
        end
    endtask

    task automatic sc_trigger();
        int i;
        int n0;
        bus(1, ACSC_IDX_COMPARE_ENABLE_BITS, 12'h000, d);
        bus(1, ACSC_IDX_CFG, 12'h001, d);
        bus(1, ACSC_IDX_CTL5, 8'h20, d);
        for (i = 0; i < 2; i++) begin
            n0 = n_starts;
            @(posedge clk);
            trig <= 1'b1;
            repeat (60) @(posedge clk);
            trig <= 1'b0;
            repeat (60) @(posedge clk);
            chk("starts per trigger", n0 + 1, n_starts);
        end
    endtask

    task automatic sc_fifo();
        int i;
        bus(1, ACSC_IDX_CFG, 12'h502, d);
        for (i = 0; i < 3; i++) begin
            bus(1, ACSC_IDX_CTL5, 8'h00, d);
            wait_done();
        end
        chk("counter wrap", 2, d[3:0]);
    endtask

    task automatic sc_abort();
        int k;
        int n0;
        bus(1, ACSC_IDX_CFG, 12'h000, d);
        bus(1, ACSC_IDX_CTL5, 8'h20, d);
        n0 = n_starts;
        repeat (100) @(negedge clk);
        chk("continuous", 1, (n_starts - n0) > 8);
        bus(1, ACSC_IDX_COMPARE_ABOVE_SELECT, 12'h000, d);
        n0 = n_starts;
        repeat (60) @(negedge clk);
        chk("no start after abort", n0, n_starts);
        @(posedge clk);
        delay <= 4'hF;
        bus(1, ACSC_IDX_CFG, 12'h300, d);
        bus(1, ACSC_IDX_CTL5, 8'h00, d);
        wait_start();
        @(negedge clk);
        n0 = n_starts;
        bus(1, ACSC_IDX_CTL5, 8'h00, d);
        for (k = 0; k < 10 && n_starts == n0; k++) @(negedge clk);
        chk("restart", n0 + 1, n_starts);
        wait_done();
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // The scenarios need about 1000 cycles; 25000 leaves a wide margin.
    initial begin
        #100000;
        n_errors++;
        tally_and_finish();
    end

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        sc_regs();
        sc_sample();
        sc_compare();
        sc_trigger();
        sc_fifo();
        sc_abort();
        tally_and_finish();
    end
endmodule // acsc_ctrl_bench
`default_nettype wire
